// ===== verilog/rid_regs.vh
`ifndef RID_REGS_VH
`define RID_REGS_VH

// ----------------------------------------
// Instruction cycle timing
// ----------------------------------------
`define RID_PHASE_FIRST 2'h0
`define RID_PHASE_LAST 2'h3
`define RID_PHASE_STEP 2'h1

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RID_CTRL_ADDR 8'h00
`define RID_STATUS_ADDR 8'h04
`define RID_LASTOP_ADDR 8'h08
`define RID_CYCLES_ADDR 8'h0C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RID_CTRL_RUN 0
`define RID_CTRL_WDEN 1
`define RID_CTRL_RESET 2'h1
`define RID_STAT_IDLE 0
`define RID_STAT_TWO 1
`define RID_STAT_PD 3
`define RID_STAT_TO 4

// ----------------------------------------
// Decoded operation codes
// ----------------------------------------
`define RID_OP_IDLE 5'h00
`define RID_OP_ADD 5'h01
`define RID_OP_SUB 5'h02
`define RID_OP_OR 5'h03
`define RID_OP_AND 5'h04
`define RID_OP_XOR 5'h05
`define RID_OP_INV 5'h06
`define RID_OP_DEC 5'h07
`define RID_OP_INC 5'h08
`define RID_OP_COPY 5'h09
`define RID_OP_SWAP 5'h0A
`define RID_OP_RLC 5'h0B
`define RID_OP_RRC 5'h0C
`define RID_OP_ZERO 5'h0D
`define RID_OP_STORE 5'h0E
`define RID_OP_DECSKIP 5'h0F
`define RID_OP_INCSKIP 5'h10
`define RID_OP_BITZERO 5'h11
`define RID_OP_BITONE 5'h12
`define RID_OP_TESTZERO 5'h13
`define RID_OP_TESTONE 5'h14
`define RID_OP_LOADLIT 5'h15
`define RID_OP_LITSUB 5'h16
`define RID_OP_CALL 5'h17
`define RID_OP_JUMP 5'h18
`define RID_OP_RET 5'h19
`define RID_OP_RETI 5'h1A
`define RID_OP_RETLIT 5'h1B
`define RID_OP_WDKICK 5'h1C
`define RID_OP_SLEEP 5'h1D

// Flag mask bits {carry, half_carry, zero}
`define RID_FL_NONE 3'h0
`define RID_FL_Z 3'h1
`define RID_FL_CZ 3'h7
`define RID_FL_C 3'h4

`endif

// ===== verilog/rid_decoder.v
`timescale 1ns/10ps
`include "rid_regs.vh"

module rid_decoder
(
  // Clock and reset
  input wire clock,
  input wire reset,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Program memory and datapath inputs
  input wire [13:0] instrWord,
  input wire [4:0] pcHighLatch,
  input wire skipTaken,
  // Decoded controls
  output reg cycleStart,
  output reg [1:0] quarterPhase,
  output reg [1:0] opClass,
  output reg [4:0] aluFunc,
  output reg destSel,
  output reg [2:0] flagMask,
  output reg twoCycle,
  output reg idleSlot,
  output reg [6:0] fileAddr,
  output reg [2:0] bitIndex,
  output reg [7:0] literal,
  output reg [12:0] jumpTarget,
  output reg stackPush,
  output reg stackPop,
  output reg watchdogClear,
  output reg sleepReq,
  output reg timeoutStatusN,
  output reg powerdownStatusN
);

  // ----------------------------------------
  // Decode function
  // ----------------------------------------
  // Packs {op[4:0], flags[2:0], dest, branch, skip}
  function [10:0] decodeWord;
    input [13:0] w;
    begin
      decodeWord = {`RID_OP_IDLE, `RID_FL_NONE, 1'b0, 1'b0, 1'b0};
      // The return, kick and sleep words come first so the wider patterns below cannot
      // swallow them; unlisted encodings fall through to idle
      casez (w)
        14'b00_0000_0000_1000:
          decodeWord = {`RID_OP_RET, `RID_FL_NONE, 3'h2};
        14'b00_0000_0000_1001:
          decodeWord = {`RID_OP_RETI, `RID_FL_NONE, 3'h2};
        14'b00_0000_0110_0100:
          decodeWord = {`RID_OP_WDKICK, `RID_FL_NONE, 3'h0};
        14'b00_0000_0110_0011:
          decodeWord = {`RID_OP_SLEEP, `RID_FL_NONE, 3'h0};
        14'b00_0000_1???_????:
          decodeWord = {`RID_OP_STORE, `RID_FL_NONE, 3'h4};
        14'b00_0000_0??0_0000:
          decodeWord = {`RID_OP_IDLE, `RID_FL_NONE, 3'h0};
        14'b00_0001_1???_????:
          decodeWord = {`RID_OP_ZERO, `RID_FL_Z, 3'h4};
        14'b00_0001_0000_0011:
          decodeWord = {`RID_OP_ZERO, `RID_FL_Z, 3'h0};
        14'b00_0111_????_????:
          decodeWord = {`RID_OP_ADD, `RID_FL_CZ, w[7], 2'h0};
        14'b00_0010_????_????:
          decodeWord = {`RID_OP_SUB, `RID_FL_CZ, w[7], 2'h0};
        14'b00_0100_????_????:
          decodeWord = {`RID_OP_OR, `RID_FL_Z, w[7], 2'h0};
        14'b00_0101_????_????:
          decodeWord = {`RID_OP_AND, `RID_FL_Z, w[7], 2'h0};
        14'b00_0110_????_????:
          decodeWord = {`RID_OP_XOR, `RID_FL_Z, w[7], 2'h0};
        14'b00_1001_????_????:
          decodeWord = {`RID_OP_INV, `RID_FL_Z, w[7], 2'h0};
        14'b00_0011_????_????:
          decodeWord = {`RID_OP_DEC, `RID_FL_Z, w[7], 2'h0};
        14'b00_1010_????_????:
          decodeWord = {`RID_OP_INC, `RID_FL_Z, w[7], 2'h0};
        14'b00_1000_????_????:
          decodeWord = {`RID_OP_COPY, `RID_FL_Z, w[7], 2'h0};
        14'b00_1110_????_????:
          decodeWord = {`RID_OP_SWAP, `RID_FL_NONE, w[7], 2'h0};
        14'b00_1101_????_????:
          decodeWord = {`RID_OP_RLC, `RID_FL_C, w[7], 2'h0};
        14'b00_1100_????_????:
          decodeWord = {`RID_OP_RRC, `RID_FL_C, w[7], 2'h0};
        14'b00_1011_????_????:
          decodeWord = {`RID_OP_DECSKIP, `RID_FL_NONE, w[7], 2'h1};
        14'b00_1111_????_????:
          decodeWord = {`RID_OP_INCSKIP, `RID_FL_NONE, w[7], 2'h1};
        14'b01_00??_????_????:
          decodeWord = {`RID_OP_BITZERO, `RID_FL_NONE, 3'h4};
        14'b01_01??_????_????:
          decodeWord = {`RID_OP_BITONE, `RID_FL_NONE, 3'h4};
        14'b01_10??_????_????:
          decodeWord = {`RID_OP_TESTZERO, `RID_FL_NONE, 3'h1};
        14'b01_11??_????_????:
          decodeWord = {`RID_OP_TESTONE, `RID_FL_NONE, 3'h1};
        14'b10_0???_????_????:
          decodeWord = {`RID_OP_CALL, `RID_FL_NONE, 3'h2};
        14'b10_1???_????_????:
          decodeWord = {`RID_OP_JUMP, `RID_FL_NONE, 3'h2};
        14'b11_00??_????_????:
          decodeWord = {`RID_OP_LOADLIT, `RID_FL_NONE, 3'h0};
        14'b11_01??_????_????:
          decodeWord = {`RID_OP_RETLIT, `RID_FL_NONE, 3'h2};
        14'b11_111?_????_????:
          decodeWord = {`RID_OP_ADD, `RID_FL_CZ, 3'h0};
        14'b11_110?_????_????:
          decodeWord = {`RID_OP_LITSUB, `RID_FL_CZ, 3'h0};
        14'b11_1001_????_????:
          decodeWord = {`RID_OP_AND, `RID_FL_Z, 3'h0};
        14'b11_1000_????_????:
          decodeWord = {`RID_OP_OR, `RID_FL_Z, 3'h0};
        14'b11_1010_????_????:
          decodeWord = {`RID_OP_XOR, `RID_FL_Z, 3'h0};
        default:
          decodeWord = {`RID_OP_IDLE, `RID_FL_NONE, 3'h0};
      endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] phase_ff;
  reg [1:0] ctrl_ff;
  // Last word actually issued; refused words leave it alone
  reg [13:0] lastOp_ff;
  reg [31:0] cycles_ff;
  reg isBranch_ff;
  reg isSkip_ff;
  wire boundary;
  wire flushNow;
  wire runEnable;
  wire [10:0] dec;
  wire [4:0] decOp;
  wire apbSetup;
  wire apbAccess;
  wire apbDone;
  wire apbKnown;
  reg [31:0] readMux;

  assign boundary = (phase_ff == `RID_PHASE_LAST);
  // A taken skip or any branch turns the next slot into an idle cycle
  assign flushNow = isBranch_ff | (isSkip_ff & skipTaken);
  assign runEnable = ctrl_ff[`RID_CTRL_RUN];
  assign dec = decodeWord(instrWord);
  assign decOp = dec[10:6];

  // ----------------------------------------
  // Quarter-phase sequencer
  // ----------------------------------------
  // The quarterPhase output mirrors phase_ff, sparing the datapath a decoder
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      phase_ff <= `RID_PHASE_FIRST;
      quarterPhase <= `RID_PHASE_FIRST;
      cycleStart <= 1'b0;
    end
    else
    begin
      phase_ff <= phase_ff + `RID_PHASE_STEP;
      quarterPhase <= phase_ff + `RID_PHASE_STEP;
      cycleStart <= boundary;
    end
  end

  // ----------------------------------------
  // Registered decode outputs
  // ----------------------------------------
  // All controls change only at the cycle boundary so the datapath sees
  // one stable set for the four quarters of the instruction cycle.
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      opClass <= 2'h0;
      aluFunc <= `RID_OP_IDLE;
      destSel <= 1'b0;
      flagMask <= `RID_FL_NONE;
      twoCycle <= 1'b0;
      idleSlot <= 1'b1;
      fileAddr <= 7'h00;
      bitIndex <= 3'h0;
      literal <= 8'h00;
      jumpTarget <= 13'h0000;
      stackPush <= 1'b0;
      stackPop <= 1'b0;
      isBranch_ff <= 1'b0;
      isSkip_ff <= 1'b0;
      lastOp_ff <= 14'h0000;
      cycles_ff <= 32'h00000000;
    end
    else if (boundary)
    begin
      // Free-running count of instruction cycles; wraps silently
      cycles_ff <= cycles_ff + 32'h00000001;
      if (flushNow || !runEnable)
      begin
        // Halted cycles and the second cycle of a branch or taken skip run as idle
        opClass <= 2'h0;
        aluFunc <= `RID_OP_IDLE;
        destSel <= 1'b0;
        flagMask <= `RID_FL_NONE;
        twoCycle <= 1'b0;
        idleSlot <= 1'b1;
        stackPush <= 1'b0;
        stackPop <= 1'b0;
        isBranch_ff <= 1'b0;
        isSkip_ff <= 1'b0;
      end
      else
      begin
        // Every field loads each cycle; the datapath ignores unused ones
        opClass <= instrWord[13:12];
        aluFunc <= decOp;
        destSel <= dec[2];
        flagMask <= dec[5:3];
        twoCycle <= dec[1] | dec[0];
        idleSlot <= (decOp == `RID_OP_IDLE);
        fileAddr <= instrWord[6:0];
        bitIndex <= instrWord[9:7];
        literal <= instrWord[7:0];
        // Upper target bits come from the high latch
        jumpTarget <= {pcHighLatch[4:3], instrWord[10:0]};
        stackPush <= (decOp == `RID_OP_CALL);
        stackPop <= (decOp == `RID_OP_RET) || (decOp == `RID_OP_RETI) ||
          (decOp == `RID_OP_RETLIT);
        isBranch_ff <= dec[1];
        isSkip_ff <= dec[0];
        lastOp_ff <= instrWord;
      end
    end
  end

  // ----------------------------------------
  // Watchdog and standby status
  // ----------------------------------------
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      timeoutStatusN <= 1'b1;
      powerdownStatusN <= 1'b1;
      watchdogClear <= 1'b0;
      sleepReq <= 1'b0;
    end
    else
    begin
      watchdogClear <= 1'b0;
      sleepReq <= 1'b0;
      if (boundary && !flushNow && runEnable)
      begin
        if (decOp == `RID_OP_WDKICK)
        begin
          watchdogClear <= 1'b1;
          timeoutStatusN <= 1'b1;
          powerdownStatusN <= 1'b1;
        end
        else if (decOp == `RID_OP_SLEEP)
        begin
          // Counter is only cleared when the watchdog runs
          watchdogClear <= ctrl_ff[`RID_CTRL_WDEN];
          sleepReq <= 1'b1;
          // Sleep sets timeout status high; nothing in this module ever drives it low
          timeoutStatusN <= 1'b1;
          powerdownStatusN <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state: pready rises in the second access cycle, which keeps
  // every bus output on a flip-flop.
  assign apbSetup = psel & ~penable;
  assign apbAccess = psel & penable & ~pready;
  // Writes land at the edge where the master sees pready high
  assign apbDone = psel & penable & pready;
  // Writes to STATUS, LASTOP and CYCLES are dropped without error
  assign apbKnown = (paddr == `RID_CTRL_ADDR) ||
    (paddr == `RID_STATUS_ADDR) || (paddr == `RID_LASTOP_ADDR) ||
    (paddr == `RID_CYCLES_ADDR);

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always @*
  begin
    readMux = 32'h00000000;
    case (paddr)
      `RID_CTRL_ADDR:
        readMux = {30'h00000000, ctrl_ff};
      `RID_STATUS_ADDR:
      begin
        readMux[`RID_STAT_IDLE] = idleSlot;
        readMux[`RID_STAT_TWO] = twoCycle;
        readMux[`RID_STAT_PD] = powerdownStatusN;
        readMux[`RID_STAT_TO] = timeoutStatusN;
      end
      `RID_LASTOP_ADDR:
        readMux = {18'h00000, lastOp_ff};
      `RID_CYCLES_ADDR:
        readMux = cycles_ff;
      default:
        readMux = 32'h00000000;
    endcase
  end

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ctrl_ff <= `RID_CTRL_RESET;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apbAccess;
      // Unmapped addresses answer with an error and read as zero
      pslverr <= apbAccess & ~apbKnown;
      // Cleared at the end of setup so a stale value never sits on the bus in the access phase
      if (apbSetup)
        prdata <= 32'h00000000;
      else if (apbAccess && !pwrite)
        prdata <= readMux;
      if (apbDone && pwrite && (paddr == `RID_CTRL_ADDR))
        ctrl_ff <= pwdata[1:0];
    end
  end

endmodule // rid_decoder

// ===== verif/rid_prog_model.sv
`timescale 1ns/10ps

module rid_prog_model
(
  // Decoder timing
  input wire [1:0] quarterPhase,
  // Program content from the bench
  input wire [13:0] wordIn,
  input wire [4:0] latchIn,
  input wire skipIn,
  // Towards the decoder
  output logic [13:0] instrWord,
  output logic [4:0] pcHighLatch,
  output logic skipTaken
);
  // ----------------------------------------
  // Fetch bus
  // ----------------------------------------
  // Valid only in the last quarter; otherwise the inverse, so a decoder
  // sampling on the wrong edge sees a wrong word, never a lucky one
  always_comb
  begin
    if (quarterPhase == 2'h3)
    begin
      instrWord = wordIn;
      pcHighLatch = latchIn;
      skipTaken = skipIn;
    end
    else
    begin
      instrWord = ~wordIn;
      pcHighLatch = ~latchIn;
      skipTaken = ~skipIn;
    end
  end
endmodule // rid_prog_model

// ===== verif/rid_decoder_properties.sv
`timescale 1ns/10ps
`include "rid_regs.vh"

module rid_decoder_properties
(
  // Clock and reset
  input wire clock,
  input wire reset,
  // Watched signals
  input wire skipTaken,
  input wire cycleStart,
  input wire [1:0] quarterPhase,
  input wire [4:0] aluFunc,
  input wire [2:0] flagMask,
  input wire idleSlot,
  input wire timeoutStatusN,
  input wire powerdownStatusN
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Decode timing and flags
  // ----------------------------------------
  property p_len;
    cycleStart |=> !cycleStart [*3] ##1 cycleStart;
  endproperty
  a_len: assert property (p_len)
    else $error("instruction cycle not four clocks");
  property p_phase;
    cycleStart |-> quarterPhase == 2'h0;
  endproperty
  a_phase: assert property (p_phase)
    else $error("cycle start off phase zero");
  property p_hold;
    !cycleStart |-> $stable(aluFunc) && $stable(flagMask);
  endproperty
  a_hold: assert property (p_hold)
    else $error("decode changed inside a cycle");
  property p_branch;
    cycleStart && aluFunc inside {[`RID_OP_CALL:`RID_OP_RETLIT]}
      |-> ##4 idleSlot && aluFunc == `RID_OP_IDLE;
  endproperty
  a_branch: assert property (p_branch)
    else $error("no idle slot after branch");
  property p_skip;
    cycleStart && aluFunc inside {`RID_OP_DECSKIP, `RID_OP_INCSKIP,
      `RID_OP_TESTZERO, `RID_OP_TESTONE} ##3 skipTaken |=> idleSlot;
  endproperty
  a_skip: assert property (p_skip)
    else $error("no idle slot after taken skip");
  property p_arith;
    cycleStart && aluFunc inside {`RID_OP_ADD, `RID_OP_SUB, `RID_OP_LITSUB}
      |-> flagMask == `RID_FL_CZ;
  endproperty
  a_arith: assert property (p_arith)
    else $error("arithmetic flag mask wrong");
  property p_logic;
    cycleStart && aluFunc inside {[`RID_OP_OR:`RID_OP_COPY]}
      |-> flagMask == `RID_FL_Z;
  endproperty
  a_logic: assert property (p_logic)
    else $error("logic flag mask wrong");
  property p_rot;
    cycleStart && aluFunc inside {`RID_OP_RLC, `RID_OP_RRC}
      |-> flagMask == `RID_FL_C;
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotate flag mask wrong");
  property p_quiet;
    cycleStart && aluFunc inside {[`RID_OP_STORE:`RID_OP_LOADLIT]}
      |-> flagMask == `RID_FL_NONE;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("flagless op marks flags");
  property p_kick;
    cycleStart && aluFunc == `RID_OP_WDKICK
      |-> timeoutStatusN && powerdownStatusN;
  endproperty
  a_kick: assert property (p_kick)
    else $error("watchdog kick status wrong");
  property p_sleep;
    cycleStart && aluFunc == `RID_OP_SLEEP
      |-> timeoutStatusN && !powerdownStatusN;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("standby status wrong");
endmodule // rid_decoder_properties

bind rid_decoder rid_decoder_properties u_props
(
  .clock(clock), .reset(reset), .skipTaken(skipTaken),
  .cycleStart(cycleStart), .quarterPhase(quarterPhase),
  .aluFunc(aluFunc), .flagMask(flagMask), .idleSlot(idleSlot),
  .timeoutStatusN(timeoutStatusN), .powerdownStatusN(powerdownStatusN)
);

// ===== verif/rid_decoder_tb_top.sv
`timescale 1ns/10ps
`include "rid_regs.vh"

module rid_decoder_tb_top;
  logic clock, reset, psel, penable, pwrite, skipIn, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [13:0] wordIn;
  logic [4:0] latchIn, op;
  wire [31:0] prdata;
  wire [13:0] instrWord;
  wire [12:0] jumpTarget;
  wire [7:0] literal;
  wire [6:0] fileAddr;
  wire [4:0] pcHighLatch, aluFunc;
  wire [2:0] flagMask, bitIndex;
  wire [1:0] quarterPhase, opClass;
  wire watchdogClear, sleepReq;
  wire pready, pslverr, skipTaken, cycleStart, destSel, twoCycle, idleSlot;
  wire stackPush, stackPop, timeoutStatusN, powerdownStatusN;
  int fails, checked, cyc;
  logic [13:0] W [37] = '{14'h3F55, 14'h3955, 14'h38AA, 14'h3A0F,
    14'h0103, 14'h3055, 14'h0000, 14'h0060, 14'h07FF, 14'h0200, 14'h0400,
    14'h0500, 14'h0600, 14'h0900, 14'h0300, 14'h0A00, 14'h0800, 14'h0E80,
    14'h0D00, 14'h0C80, 14'h0180, 14'h0080, 14'h0B00, 14'h0F80, 14'h13FF,
    14'h1680, 14'h1A55, 14'h1D2A, 14'h3355, 14'h3DAA, 14'h2000, 14'h2FFF,
    14'h0008, 14'h0009, 14'h37C3, 14'h0064, 14'h0063};
  logic [4:0] E [7] = '{5'h01, 5'h04, 5'h03, 5'h05, 5'h0D, 5'h15, 5'h00};
  logic [13:0] S [4] = '{14'h0B00, 14'h0F00, 14'h1800, 14'h1C00};

  rid_decoder u_dut
  (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instrWord(instrWord),
    .pcHighLatch(pcHighLatch), .skipTaken(skipTaken),
    .cycleStart(cycleStart), .quarterPhase(quarterPhase),
    .opClass(opClass),
    .aluFunc(aluFunc), .destSel(destSel), .flagMask(flagMask),
    .twoCycle(twoCycle), .idleSlot(idleSlot), .fileAddr(fileAddr),
    .bitIndex(bitIndex), .literal(literal), .jumpTarget(jumpTarget),
    .stackPush(stackPush), .stackPop(stackPop),
    .watchdogClear(watchdogClear), .sleepReq(sleepReq),
    .timeoutStatusN(timeoutStatusN),
    .powerdownStatusN(powerdownStatusN)
  );
  rid_prog_model u_prog
  (
    .quarterPhase(quarterPhase), .wordIn(wordIn), .latchIn(latchIn),
    .skipIn(skipIn), .instrWord(instrWord), .pcHighLatch(pcHighLatch),
    .skipTaken(skipTaken)
  );

  // ----------------------------------------
  // Clock, timeout and checking helpers
  // ----------------------------------------
  always #10 clock = ~clock;
  // Far above the few hundred cycles the sequence needs
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      complete_run;
    end
  end

  task complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Present a word and return one clock into the cycle that executes it
  task step(input logic [13:0] w, input logic s);
    wordIn <= w;
    skipIn <= s;
    // Let the word settle first: a call on a boundary edge would miss it
    @(posedge clock);
    do @(posedge clock); while (cycleStart !== 1'b1);
  endtask

  function logic [2:0] fl(input logic [4:0] o);
    case (o)
      5'h01, 5'h02, 5'h16: fl = `RID_FL_CZ;
      5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0D: fl = `RID_FL_Z;
      5'h0B, 5'h0C: fl = `RID_FL_C;
      default: fl = `RID_FL_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clock = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; wordIn = 0; skipIn = 0; latchIn = 5'h0D;
    fails = 0; checked = 0; cyc = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, `RID_CTRL_ADDR, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    for (int i = 0; i < 37; i++)
    begin
      op = (i < 7) ? E[i] : 5'(i - 7);
      step(W[i], 1'b0);
      chk("op", aluFunc, op);
      chk("flags", flagMask, fl(op));
      chk("class", opClass, W[i][13:12]);
      chk("wd clear", watchdogClear, op == 5'h1C);
      chk("standby", sleepReq, op == 5'h1D);
      chk("two", twoCycle, op inside {5'h0F, 5'h10, [5'h13:5'h14],
        [5'h17:5'h1B]});
      if (W[i][13:12] == 2'b00 && op != 5'h00 && op <= 5'h10)
        chk("dest", destSel, W[i][7]);
      if (!W[i][13] && (W[i][12] || W[i][6:0] == 7'h7F))
        chk("addr", fileAddr, W[i][6:0]);
      if (W[i][13:12] == 2'b01)
        chk("bit", bitIndex, W[i][9:7]);
      if (W[i][13:12] == 2'b11)
        chk("lit", literal, W[i][7:0]);
      if (op == 5'h17 || op == 5'h18)
        chk("target", jumpTarget, {latchIn[4:3], W[i][10:0]});
      if (op >= 5'h17 && op <= 5'h1B)
      begin
        chk("push", stackPush, op == 5'h17);
        chk("pop", stackPop, op >= 5'h19);
        step(14'h0780, 1'b0);
        chk("slot op", aluFunc, `RID_OP_IDLE);
        chk("slot", idleSlot, 1'b1);
      end
      if (op >= 5'h1C)
        chk("status", {timeoutStatusN, powerdownStatusN},
          {1'b1, op == 5'h1C});
    end
    for (int i = 0; i < 4; i++)
    begin
      step(S[i], 1'b0);
      step(14'h0780, i[0]);
      chk("skip", aluFunc, i[0] ? `RID_OP_IDLE : `RID_OP_ADD);
    end
    apb(1'b0, `RID_LASTOP_ADDR, 32'h0);
    chk("lastop", rd, 32'h00001C00);
    step(14'h0000, 1'b0);
    apb(1'b0, `RID_STATUS_ADDR, 32'h0);
    chk("status reg", rd, 32'h00000011);
    apb(1'b1, `RID_CYCLES_ADDR, 32'h5);
    chk("ro write err", err, 1'b0);
    apb(1'b1, `RID_CTRL_ADDR, 32'h0);
    step(14'h0000, 1'b0);
    step(14'h0780, 1'b0);
    chk("halted", aluFunc, `RID_OP_IDLE);
    apb(1'b1, `RID_CTRL_ADDR, 32'h3);
    apb(1'b0, `RID_CTRL_ADDR, 32'h0);
    chk("ctrl", rd[1:0], 2'h3);
    step(14'h0063, 1'b0);
    chk("sleep wd", watchdogClear, 1'b1);
    step(14'h0064, 1'b0);
    chk("kick", {timeoutStatusN, powerdownStatusN}, 2'b11);
    complete_run;
  end
endmodule // rid_decoder_tb_top
